// [dscd_pkg.sv]
`default_nettype none
package dscd_pkg;
	// Command opcodes.
	localparam logic [7:0] OP_SCAN_NORMAL = 8'hc0;
	localparam logic [7:0] OP_SCAN_REMAP = 8'hc8;
	localparam logic [7:0] OP_OFFSET = 8'hd3;
	localparam logic [7:0] OP_SOFT_RESET = 8'he2;
	localparam logic [7:0] OP_NO_OPERATION = 8'he3;
	localparam logic [7:0] OP_BIAS = 8'he9;
	localparam logic [7:0] OP_OSC = 8'hf6;
	localparam logic [7:0] OP_CLK_OUT = 8'hfe;
	localparam logic [7:0] OP_REFRESH = 8'h31;
	// Parameter codes.
	localparam logic [7:0] PAR_BIAS_ON = 8'h84;
	localparam logic [7:0] PAR_BIAS_OFF = 8'h04;
	localparam logic [7:0] PAR_OSC_ON = 8'h40;
	localparam logic [7:0] PAR_OSC_OFF = 8'h00;
	localparam logic [7:0] PAR_CLK_ON = 8'h80;
	localparam logic [7:0] PAR_CLK_OFF = 8'h00;
	// Field widths and reset values.
	localparam int OFFSET_W = 6;
	localparam logic [5:0] OFFSET_RST = 6'h00;
	localparam logic SCAN_RST = 1'b0;
	localparam logic BIAS_RST = 1'b0;
	localparam logic OSC_RST = 1'b0;
	localparam logic CLK_RST = 1'b0;
	// Timing of the display oscillator.
	localparam int SYS_CLK_HZ = 50000000;
	localparam int OSC_KHZ = 200;
	localparam int OSC_HALF_CYC = SYS_CLK_HZ / (OSC_KHZ * 1000 * 2);
	// Decoder states.
	typedef enum logic [2:0] {
		DSCD_IDLE, DSCD_OFFSET, DSCD_RESET2, DSCD_BIAS, DSCD_OSC, DSCD_CLK
	} dscd_state_e;
endpackage
`default_nettype wire

// [dscd_decoder.sv]
// Function
// R1: Two opcodes select common scan direction.
// R2: C0h normal order, C8h reversed order.
// R3: Scan direction applied at next refresh.
// R4: Host issues refresh after changing settings.
// R5: Offset opcode takes one data byte.
// R6: Offset maps start line onto a common.
// R7: Offset N shifts image toward COM0.
// R8: Six-bit offset wraps modulo 64.
// R9: E2h then E3h resets; E3h alone nothing.
// R10: E9h with 84h/04h switches bias ladder.
// R11: F6h with 40h/00h starts/stops oscillator.
// R12: FEh with 80h/00h gates clock, sync outputs.
// R13: Oscillator clocks timing at 200 kHz.
// R14: Unknown parameter codes are ignored.
`default_nettype none
module dscd_decoder (
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Command byte strobe from the host interface, same clock domain.
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_byte_in,
	// Applied display settings.
	output logic scan_remap_out,
	output logic [5:0] offset_out,
	output logic refresh_out,
	// Analog and clock controls.
	output logic bias_en_out,
	output logic osc_en_out,
	output logic clock_mode_out,
	output logic osc_tick_out,
	output logic clock_out_pin,
	output logic sync_out_m,
	output logic sync_out_c,
	output logic sync_out_d
);
	// Decoder state.
	dscd_pkg::dscd_state_e state_reg, state_next;
	// Scan direction written by the host and the one applied to the panel.
	logic scan_pend_reg, scan_pend_next;
	logic scan_reg, scan_next;
	// Offset field.
	logic [5:0] offset_reg, offset_next;
	// One-cycle refresh pulse.
	logic refresh_reg, refresh_next;
	// Enables.
	logic bias_reg, bias_next;
	logic osc_reg, osc_next;
	logic clk_reg, clk_next;
	// Oscillator divider and its output level.
	logic [15:0] div_reg, div_next;
	logic osc_lvl_reg, osc_lvl_next;
	logic tick_reg, tick_next;
	logic sync_m_reg, sync_m_next;
	logic sync_c_reg, sync_c_next;
	logic sync_d_reg, sync_d_next;
	logic clk_pin_reg, clk_pin_next;

	// Command decoding: next state and settings.
	always_comb begin
		state_next = state_reg;
		scan_pend_next = scan_pend_reg;
		scan_next = scan_reg;
		offset_next = offset_reg;
		refresh_next = 1'b0;
		bias_next = bias_reg;
		osc_next = osc_reg;
		clk_next = clk_reg;
		if (cmd_valid_in) begin
			case (state_reg)
				dscd_pkg::DSCD_OFFSET: begin
					// The byte is data, never an opcode.
					offset_next = cmd_byte_in[dscd_pkg::OFFSET_W-1:0]; // R5 R6 R7 R8
					state_next = dscd_pkg::DSCD_IDLE;
				end
				dscd_pkg::DSCD_RESET2: begin
					if (cmd_byte_in == dscd_pkg::OP_NO_OPERATION) begin
						// Full return to the initial state.
						scan_pend_next = dscd_pkg::SCAN_RST; // R9
						scan_next = dscd_pkg::SCAN_RST;
						offset_next = dscd_pkg::OFFSET_RST;
						bias_next = dscd_pkg::BIAS_RST;
						osc_next = dscd_pkg::OSC_RST;
						clk_next = dscd_pkg::CLK_RST;
						state_next = dscd_pkg::DSCD_IDLE;
					end else if (cmd_byte_in == dscd_pkg::OP_SOFT_RESET) begin
						// A repeated first byte keeps the sequence armed.
						state_next = dscd_pkg::DSCD_RESET2;
					end else begin
						// Any other byte breaks the sequence and runs as a fresh opcode.
						state_next = dscd_pkg::DSCD_IDLE;
						if (cmd_byte_in == dscd_pkg::OP_SCAN_NORMAL) begin
							scan_pend_next = 1'b0;
						end else if (cmd_byte_in == dscd_pkg::OP_SCAN_REMAP) begin
							scan_pend_next = 1'b1;
						end else if (cmd_byte_in == dscd_pkg::OP_REFRESH) begin
							scan_next = scan_pend_reg;
							refresh_next = 1'b1;
						end else if (cmd_byte_in == dscd_pkg::OP_OFFSET) begin
							state_next = dscd_pkg::DSCD_OFFSET;
						end else if (cmd_byte_in == dscd_pkg::OP_BIAS) begin
							state_next = dscd_pkg::DSCD_BIAS;
						end else if (cmd_byte_in == dscd_pkg::OP_OSC) begin
							state_next = dscd_pkg::DSCD_OSC;
						end else if (cmd_byte_in == dscd_pkg::OP_CLK_OUT) begin
							state_next = dscd_pkg::DSCD_CLK;
						end
					end
				end
				dscd_pkg::DSCD_BIAS: begin
					// Only the two documented codes act.
					if (cmd_byte_in == dscd_pkg::PAR_BIAS_ON) begin
						bias_next = 1'b1; // R10
					end else if (cmd_byte_in == dscd_pkg::PAR_BIAS_OFF) begin
						bias_next = 1'b0; // R10 R14
					end
					state_next = dscd_pkg::DSCD_IDLE;
				end
				dscd_pkg::DSCD_OSC: begin
					if (cmd_byte_in == dscd_pkg::PAR_OSC_ON) begin
						osc_next = 1'b1; // R11
					end else if (cmd_byte_in == dscd_pkg::PAR_OSC_OFF) begin
						osc_next = 1'b0; // R11 R14
					end
					state_next = dscd_pkg::DSCD_IDLE;
				end
				dscd_pkg::DSCD_CLK: begin
					if (cmd_byte_in == dscd_pkg::PAR_CLK_ON) begin
						clk_next = 1'b1; // R12
					end else if (cmd_byte_in == dscd_pkg::PAR_CLK_OFF) begin
						clk_next = 1'b0; // R12 R14
					end
					state_next = dscd_pkg::DSCD_IDLE;
				end
				default: begin
					// Idle: byte is an opcode.
					if (cmd_byte_in == dscd_pkg::OP_SCAN_NORMAL) begin
						scan_pend_next = 1'b0; // R1 R2
					end else if (cmd_byte_in == dscd_pkg::OP_SCAN_REMAP) begin
						scan_pend_next = 1'b1; // R1 R2
					end else if (cmd_byte_in == dscd_pkg::OP_REFRESH) begin
						// Pending direction reaches the panel only on a refresh opcode, here or in DSCD_RESET2.
						scan_next = scan_pend_reg; // R3 R4
						refresh_next = 1'b1;
					end else if (cmd_byte_in == dscd_pkg::OP_OFFSET) begin
						state_next = dscd_pkg::DSCD_OFFSET; // R5
					end else if (cmd_byte_in == dscd_pkg::OP_SOFT_RESET) begin
						state_next = dscd_pkg::DSCD_RESET2; // R9
					end else if (cmd_byte_in == dscd_pkg::OP_BIAS) begin
						state_next = dscd_pkg::DSCD_BIAS;
					end else if (cmd_byte_in == dscd_pkg::OP_OSC) begin
						state_next = dscd_pkg::DSCD_OSC;
					end else if (cmd_byte_in == dscd_pkg::OP_CLK_OUT) begin
						state_next = dscd_pkg::DSCD_CLK;
					end
					// No-operation and unknown opcodes leave everything as is.
				end
			endcase
		end
	end

	// Oscillator divider and clock/sync outputs.
	always_comb begin
		div_next = div_reg;
		osc_lvl_next = osc_lvl_reg;
		tick_next = 1'b0;
		if (!osc_reg) begin
			div_next = 16'h0000;
			osc_lvl_next = 1'b0;
		end else if (div_reg == 16'(dscd_pkg::OSC_HALF_CYC - 1)) begin
			// Half period reached: toggle the 200 kHz level.
			div_next = 16'h0000; // R13
			osc_lvl_next = !osc_lvl_reg;
			tick_next = !osc_lvl_reg;
		end else begin
			div_next = div_reg + 16'h0001;
		end
		// Outputs stay low unless clock mode is on.
		clk_pin_next = clk_reg & osc_lvl_next; // R12
		sync_m_next = clk_reg & osc_reg;
		sync_c_next = clk_reg & refresh_next;
		sync_d_next = clk_reg & tick_next;
	end

	// State registers.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= dscd_pkg::DSCD_IDLE;
			scan_pend_reg <= dscd_pkg::SCAN_RST;
			scan_reg <= dscd_pkg::SCAN_RST;
			offset_reg <= dscd_pkg::OFFSET_RST;
			refresh_reg <= 1'b0;
			bias_reg <= dscd_pkg::BIAS_RST;
			osc_reg <= dscd_pkg::OSC_RST;
			clk_reg <= dscd_pkg::CLK_RST;
			div_reg <= 16'h0000;
			osc_lvl_reg <= 1'b0;
			tick_reg <= 1'b0;
			clk_pin_reg <= 1'b0;
			sync_m_reg <= 1'b0;
			sync_c_reg <= 1'b0;
			sync_d_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			scan_pend_reg <= scan_pend_next;
			scan_reg <= scan_next;
			offset_reg <= offset_next;
			refresh_reg <= refresh_next;
			bias_reg <= bias_next;
			osc_reg <= osc_next;
			clk_reg <= clk_next;
			div_reg <= div_next;
			osc_lvl_reg <= osc_lvl_next;
			tick_reg <= tick_next;
			clk_pin_reg <= clk_pin_next;
			sync_m_reg <= sync_m_next;
			sync_c_reg <= sync_c_next;
			sync_d_reg <= sync_d_next;
		end
	end

	// Outputs come straight from flip-flops.
	assign scan_remap_out = scan_reg;
	assign offset_out = offset_reg;
	assign refresh_out = refresh_reg;
	assign bias_en_out = bias_reg;
	assign osc_en_out = osc_reg;
	assign clock_mode_out = clk_reg;
	assign osc_tick_out = tick_reg;
	assign clock_out_pin = clk_pin_reg;
	assign sync_out_m = sync_m_reg;
	assign sync_out_c = sync_c_reg;
	assign sync_out_d = sync_d_reg;
endmodule
`default_nettype wire

// [dscd_decoder_props.sv]
`default_nettype none
module dscd_decoder_chk (
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Command strobe.
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_byte_in,
	// Decoder outputs.
	input wire logic scan_remap_out,
	input wire logic [5:0] offset_out,
	input wire logic refresh_out,
	input wire logic bias_en_out,
	input wire logic osc_en_out,
	input wire logic clock_mode_out,
	input wire logic osc_tick_out,
	input wire logic clock_out_pin,
	input wire logic sync_out_m,
	input wire logic sync_out_c,
	input wire logic sync_out_d
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// High when the next valid byte is the parameter of a two-byte command.
	logic par_due_reg, par_due_next;
	// Tracks which bytes are opcodes, so a parameter that looks like an opcode is not misread.
	always_comb begin
		par_due_next = par_due_reg;
		if (cmd_valid_in) begin
			par_due_next = !par_due_reg && (cmd_byte_in inside {8'hd3, 8'he9, 8'hf6, 8'hfe});
		end
	end
	// Registers the parameter tracker.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			par_due_reg <= 1'b0;
		end else begin
			par_due_reg <= par_due_next;
		end
	end
	// An opcode taken, then any byte taken on the next edge.
	sequence s_param(op);
		cmd_valid_in && !par_due_reg && cmd_byte_in == op ##1 cmd_valid_in;
	endsequence
	// An opcode taken, then its parameter taken on the next edge.
	sequence s_cmd(op, par);
		s_param(op) ##0 cmd_byte_in == par;
	endsequence
	property p_refresh; cmd_valid_in && !par_due_reg && cmd_byte_in == 8'h31 |=> refresh_out;
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh pulse missing");
	property p_scan; $changed(scan_remap_out) |-> refresh_out || $past(cmd_byte_in == 8'he3); endproperty
	a_scan: assert property (p_scan) else $error("scan changed early");
	property p_offset; s_param(8'hd3) |=> offset_out == $past(cmd_byte_in[5:0]); endproperty
	a_offset: assert property (p_offset) else $error("offset wrong");
	property p_bias; s_cmd(8'he9, 8'h84) |=> bias_en_out; endproperty
	a_bias: assert property (p_bias) else $error("bias not on");
	property p_clk; s_cmd(8'hfe, 8'h80) |=> clock_mode_out; endproperty
	a_clk: assert property (p_clk) else $error("clock mode not on");
	property p_soft; s_cmd(8'he2, 8'he3) |=> !bias_en_out && !osc_en_out && !clock_mode_out
		&& !scan_remap_out && offset_out == 6'h00; endproperty
	a_soft: assert property (p_soft) else $error("soft reset incomplete");
	property p_ignore; s_param(8'he9) ##0 !(cmd_byte_in inside {8'h84, 8'h04})
		|=> $stable(bias_en_out); endproperty
	a_ignore: assert property (p_ignore) else $error("bad code changed bias");
	property p_osc; s_cmd(8'hf6, 8'h40) |=> osc_en_out; endproperty
	a_osc: assert property (p_osc) else $error("oscillator not on");
	// The sync pulses follow refresh and tick, gated by the clock mode of the launching cycle.
	property p_sync_c; sync_out_c == (refresh_out && $past(clock_mode_out)); endproperty
	a_sync_c: assert property (p_sync_c) else $error("sync c pulse wrong");
	property p_sync_d; sync_out_d == (osc_tick_out && $past(clock_mode_out)); endproperty
	a_sync_d: assert property (p_sync_d) else $error("sync d pulse wrong");
	property p_gated; !clock_mode_out && !$past(clock_mode_out)
		|-> !clock_out_pin && !sync_out_m && !sync_out_c && !sync_out_d; endproperty
	a_gated: assert property (p_gated) else $error("clock outputs while off");
	property p_tick; osc_tick_out |=> !osc_tick_out [*8]; endproperty
	a_tick: assert property (p_tick) else $error("tick too soon");
endmodule
bind dscd_decoder dscd_decoder_chk dscd_decoder_chk_i (.*);
`default_nettype wire

// [dscd_host.sv]
`default_nettype none
module dscd_host (
	// Clock.
	input wire logic clk_sys_in,
	// Command strobe towards the decoder.
	output logic cmd_valid_out,
	output logic [7:0] cmd_byte_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		cmd_valid_out = 1'b0;
		cmd_byte_out = 8'h00;
	end
	// One byte; with more set the strobe stays up so the next byte follows back to back.
	task automatic send(input logic [7:0] b, input bit more);
		@(posedge clk_sys_in);
		cmd_valid_out <= 1'b1;
		cmd_byte_out <= b;
		if (!more) begin
			@(posedge clk_sys_in);
			cmd_valid_out <= 1'b0;
			cmd_byte_out <= ~b;
		end
	endtask
	// Opcode with its parameter byte right behind it.
	task automatic pair(input logic [7:0] op, input logic [7:0] par);
		send(op, 1'b1);
		send(par, 1'b0);
	endtask
endmodule
`default_nettype wire

// [test_display_setup_command_decoder.sv]
`default_nettype none
module test_display_setup_command_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] op; logic [7:0] par; logic [9:0] exp;} dscd_row_s;
	// Opcode, parameter, then expected {scan, bias, osc, clock mode, offset}.
	dscd_row_s rows [16] = '{'{8'he9, 8'h84, 10'h100}, '{8'he9, 8'h55, 10'h100},
		'{8'hf6, 8'h40, 10'h180}, '{8'hf6, 8'hab, 10'h180}, '{8'hfe, 8'h80, 10'h1c0},
		'{8'hfe, 8'h7f, 10'h1c0}, '{8'hd3, 8'h10, 10'h1d0}, '{8'hd3, 8'h30, 10'h1f0},
		'{8'hd3, 8'hff, 10'h1ff}, '{8'hc8, 8'h31, 10'h3ff}, '{8'he3, 8'he3, 10'h3ff},
		'{8'hc0, 8'h31, 10'h1ff}, '{8'hfe, 8'h00, 10'h1bf}, '{8'hf6, 8'h00, 10'h13f},
		'{8'he9, 8'h04, 10'h03f}, '{8'hd3, 8'h00, 10'h000}};
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic cmd_valid_in;
	logic [7:0] cmd_byte_in;
	logic scan_remap_out, refresh_out, bias_en_out, osc_en_out, clock_mode_out;
	logic osc_tick_out, clock_out_pin, sync_out_m, sync_out_c, sync_out_d;
	logic [5:0] offset_out;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	int ticks = 0;
	// Sync pulses and clock pin high cycles seen in the counting window.
	int pulses = 0;
	int highs = 0;
	always #10 clk_sys_in = ~clk_sys_in;
	// Design under test, every port connected by name.
	dscd_decoder dscd_decoder_i (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.cmd_valid_in(cmd_valid_in),
		.cmd_byte_in(cmd_byte_in),
		.scan_remap_out(scan_remap_out),
		.offset_out(offset_out),
		.refresh_out(refresh_out),
		.bias_en_out(bias_en_out),
		.osc_en_out(osc_en_out),
		.clock_mode_out(clock_mode_out),
		.osc_tick_out(osc_tick_out),
		.clock_out_pin(clock_out_pin),
		.sync_out_m(sync_out_m),
		.sync_out_c(sync_out_c),
		.sync_out_d(sync_out_d)
	);
	dscd_host dscd_host_i (.clk_sys_in, .cmd_valid_out(cmd_valid_in), .cmd_byte_out(cmd_byte_in));
	function automatic logic [9:0] state_now();
		return {scan_remap_out, bias_en_out, osc_en_out, clock_mode_out, offset_out};
	endfunction
	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		if (num_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Cuts a hang short.
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		repeat (20) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		foreach (rows[i]) begin
			dscd_host_i.pair(rows[i].op, rows[i].par);
			#1;
			check("settings", state_now(), rows[i].exp);
		end
		dscd_host_i.send(8'hc8, 1'b0);
		#1;
		check("scan early", scan_remap_out, 1'b0);
		dscd_host_i.send(8'h31, 1'b0);
		#1;
		check("refresh", {refresh_out, scan_remap_out}, 2'b11);
		dscd_host_i.pair(8'he9, 8'h84);
		dscd_host_i.pair(8'he2, 8'he3);
		#1;
		check("soft reset", state_now(), 10'h000);
		// A repeated first reset byte stays armed; another opcode then cancels the reset.
		dscd_host_i.send(8'he2, 1'b1);
		dscd_host_i.send(8'he2, 1'b1);
		dscd_host_i.pair(8'he9, 8'h84);
		#1;
		check("reset cancel", state_now(), 10'h100);
		dscd_host_i.pair(8'hf6, 8'h40);
		dscd_host_i.pair(8'hfe, 8'h80);
		while (osc_tick_out !== 1'b1 && ticks < 300) begin
			@(posedge clk_sys_in);
			#1;
			ticks++;
		end
		ticks = 0;
		repeat (1000) begin
			@(posedge clk_sys_in);
			#1;
			ticks += osc_tick_out;
			pulses += sync_out_d;
			highs += clock_out_pin;
		end
		check("ticks", ticks[9:0], 10'd4);
		check("sync d", pulses[9:0], 10'd4);
		// A 200 kHz square wave is high for half of 1000 system cycles.
		check("clock pin", highs[9:0], 10'd500);
		check("sync m", sync_out_m, 1'b1);
		// With clock mode on, a refresh also pulses the sync output.
		dscd_host_i.send(8'h31, 1'b0);
		#1;
		check("sync c", {refresh_out, sync_out_c}, 2'b11);
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		#1;
		check("hard reset", state_now(), 10'h000);
		results();
	end
endmodule
`default_nettype wire
